// >>> design/pasp_pkg.sv
// constants and types shared by the primary serial port transmit formatter
package pasp_pkg;
    // register map
    localparam logic [7:0] FMT_ADDR = 8'h1A;
    localparam logic [7:0] DRV_ADDR = 8'h1B;
    localparam logic [7:0] OFS_ADDR = 8'h1C;
    localparam logic [7:0] FMT_RST  = 8'h30;
    localparam logic [7:0] DRV_RST  = 8'h00;
    localparam logic [4:0] OFS_RST  = 5'h00;
    // primary_serial_format_config fields
    localparam int PROTO_MSB   = 7;
    localparam int PROTO_LSB   = 6;
    localparam int WLEN_MSB    = 5;
    localparam int WLEN_LSB    = 4;
    localparam int FS_INV_BIT  = 3;
    localparam int BCK_INV_BIT = 2;
    localparam int ERR_OFF_BIT = 1;
    localparam int RES_OFF_BIT = 0;
    // primary_serial_tx_drive_config fields
    localparam int EDGE_BIT    = 7;
    localparam int FILL_BIT    = 6;
    localparam int LSBH_BIT    = 5;
    localparam int KEEP_MSB    = 4;
    localparam int KEEP_LSB    = 3;
    localparam int INT_FS_BIT  = 2;
    localparam int INT_BCK_BIT = 1;
    localparam int WIDE_BIT    = 0;
    // primary_serial_tx_msb_offset field
    localparam int OFS_W       = 5;
    // encodings
    localparam logic [1:0] PROTO_TDM = 2'h0;
    localparam logic [1:0] PROTO_I2S = 2'h1;
    localparam logic [1:0] PROTO_LJ  = 2'h2;
    localparam logic [1:0] KEEP_OFF  = 2'h0;
    localparam logic [1:0] KEEP_ON   = 2'h1;
    localparam logic [1:0] KEEP_LSB1 = 2'h2;
    localparam logic [1:0] KEEP_LSB3 = 2'h3;
    // bit-clock counters, internal frame length and settings word width
    localparam int         CNT_W       = 11;
    localparam logic [10:0] FRAME_BCLKS = 11'h040;
    localparam logic [10:0] HALF_BCLKS  = 11'h020;
    localparam int         CFG_W       = 21;

    typedef enum logic [2:0] {
        LNK_RUN  = 3'b001,
        LNK_ERR  = 3'b010,
        LNK_DOWN = 3'b100
    } pasp_link_state_type;
endpackage : pasp_pkg

// >>> design/pasp_pin_stage.sv
// launch stage for the two data pins: edge choice, lsb shortening, keeper
`timescale 1ns/1ps
`default_nettype none
module pasp_pin_stage (
    // link clock and reset
    input  wire logic       bclk_i,
    input  wire logic       rst_n_i,
    // bit stream from the formatter
    input  wire logic [1:0] bit_i,
    input  wire logic [1:0] act_i,
    input  wire logic [1:0] lsb_i,
    // drive settings
    input  wire logic       fill_hiz_i,
    input  wire logic       lsb_half_i,
    input  wire logic [1:0] keep_mode_i,
    input  wire logic       edge_late_i,
    // pins
    output logic [1:0]      data_o,
    output logic [1:0]      data_oe_o,
    output logic [1:0]      keeper_o
);
    // a: falling edge, b: next rising edge, c: falling edge after b
    logic [1:0] a_d_ff, a_oe_ff, a_l_ff;
    logic [1:0] b_d_ff, b_oe_ff, b_l_ff;
    logic [1:0] c_l_ff;
    logic [1:0] nxt_a_oe;
    logic [1:0] lch_oe, lch_l, fol_l;

    always_comb
    begin
        nxt_a_oe = act_i | {2{~fill_hiz_i}};
    end

    always_ff @(negedge bclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            a_d_ff  <= 2'h0;
            a_oe_ff <= 2'h0;
            a_l_ff  <= 2'h0;
            c_l_ff  <= 2'h0;
        end
        else
        begin
            a_d_ff  <= bit_i & act_i;
            a_oe_ff <= nxt_a_oe;
            a_l_ff  <= lsb_i & act_i;
            c_l_ff  <= b_l_ff;
        end
    end

    always_ff @(posedge bclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            b_d_ff  <= 2'h0;
            b_oe_ff <= 2'h0;
            b_l_ff  <= 2'h0;
        end
        else
        begin
            b_d_ff  <= a_d_ff;
            b_oe_ff <= a_oe_ff;
            b_l_ff  <= a_l_ff;
        end
    end

    // late launch moves every pin change half a bit clock on
    always_comb
    begin
        lch_oe = edge_late_i ? b_oe_ff : a_oe_ff;
        lch_l  = edge_late_i ? b_l_ff : a_l_ff;
        fol_l  = edge_late_i ? c_l_ff : b_l_ff;
        data_o = edge_late_i ? b_d_ff : a_d_ff;
        // second half of the lsb cycle released when shortening
        data_oe_o = lch_oe & ~({2{lsb_half_i}} & lch_l & fol_l);
        case (keep_mode_i)
            pasp_pkg::KEEP_ON:   keeper_o = 2'h3;
            pasp_pkg::KEEP_LSB1: keeper_o = lch_l;
            pasp_pkg::KEEP_LSB3: keeper_o = lch_l | fol_l;
            default:             keeper_o = 2'h0;
        endcase
    end

    keeper_off_a: assert property (@(posedge bclk_i) disable iff (!rst_n_i)
        (keep_mode_i == pasp_pkg::KEEP_OFF) |-> (keeper_o == 2'h0))
        else $error("keeper active while disabled");
    fill_zero_a: assert property (@(posedge bclk_i) disable iff (!rst_n_i)
        (!fill_hiz_i && !lsb_half_i) [*2] |-> (data_oe_o == 2'h3))
        else $error("pin released while zero fill selected");
endmodule : pasp_pin_stage
`default_nettype wire

// >>> design/pasp_tx_format.sv
// primary serial port configuration registers and transmit formatter
`timescale 1ns/1ps
`default_nettype none
module pasp_tx_format (
    // system
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    // status
    output logic             bus_error_o,
    output logic             int_bclk_sel_o,
    // link
    input  wire logic        bit_clock_i,
    input  wire logic        frame_sync_i,
    input  wire logic        controller_mode_i,
    input  wire logic [31:0] tx_word0_i,
    input  wire logic [31:0] tx_word1_i,
    input  wire logic [4:0]  tx_slot0_i,
    input  wire logic [4:0]  tx_slot1_i,
    input  wire logic [1:0]  tx_en_i,
    output logic             frame_sync_o,
    output logic             frame_sync_oe_o,
    output logic [1:0]       data_o,
    output logic [1:0]       data_oe_o,
    output logic [1:0]       keeper_o
);
    function automatic logic [5:0] word_len(input logic [1:0] code);
        case (code)
            2'h0:    word_len = 6'h10;
            2'h1:    word_len = 6'h14;
            2'h2:    word_len = 6'h18;
            default: word_len = 6'h20;
        endcase
    endfunction : word_len

    function automatic logic [4:0] slot_index(input logic [4:0] code, input logic tdm);
        slot_index = tdm ? code : {1'b0, code[3:0]};
    endfunction : slot_index

    // ---------------- register clock domain
    logic                  rs1_ff, rsys_n_ff;
    logic [7:0]            fmt_ff, drv_ff, rdata_ff;
    logic [4:0]            ofs_ff;
    logic [pasp_pkg::CFG_W-1:0] shadow_ff;
    logic                  req_ff, dirty_ff, ack_s1_ff, ack_s2_ff;
    logic                  err_s1_ff, err_s2_ff, cm_s1_ff, cm_s2_ff, ibck_ff;
    // link-side handshake return and link state, read by the synchronisers below
    logic                  ack_ff;
    pasp_pkg::pasp_link_state_type st_ff;
    logic [7:0]            nxt_fmt, nxt_drv, nxt_rdata;
    logic [4:0]            nxt_ofs;
    logic [pasp_pkg::CFG_W-1:0] nxt_shadow;
    logic                  nxt_req, nxt_dirty, launch, wr_hit;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rs1_ff    <= 1'b0;
            rsys_n_ff <= 1'b0;
        end
        else
        begin
            rs1_ff    <= 1'b1;
            rsys_n_ff <= rs1_ff;
        end
    end

    always_comb
    begin
        wr_hit  = reg_wr_i && (reg_addr_i inside {pasp_pkg::FMT_ADDR, pasp_pkg::DRV_ADDR,
                                                  pasp_pkg::OFS_ADDR});
        nxt_fmt = (reg_wr_i && reg_addr_i == pasp_pkg::FMT_ADDR) ? reg_wdata_i : fmt_ff;
        nxt_drv = (reg_wr_i && reg_addr_i == pasp_pkg::DRV_ADDR) ? reg_wdata_i : drv_ff;
        // upper offset bits are not stored
        nxt_ofs = (reg_wr_i && reg_addr_i == pasp_pkg::OFS_ADDR) ? reg_wdata_i[4:0] : ofs_ff;
        case (reg_addr_i)
            pasp_pkg::FMT_ADDR: nxt_rdata = fmt_ff;
            pasp_pkg::DRV_ADDR: nxt_rdata = drv_ff;
            pasp_pkg::OFS_ADDR: nxt_rdata = {3'h0, ofs_ff};
            default:            nxt_rdata = 8'h00;
        endcase
        // one settings word in flight; it stays frozen until acknowledged
        launch     = dirty_ff && (req_ff == ack_s2_ff);
        nxt_dirty  = wr_hit || (dirty_ff && !launch);
        nxt_req    = launch ? ~req_ff : req_ff;
        nxt_shadow = launch ? {fmt_ff, drv_ff, ofs_ff} : shadow_ff;
    end

    always_ff @(posedge clock_i or negedge rsys_n_ff)
    begin
        if (!rsys_n_ff)
        begin
            fmt_ff    <= pasp_pkg::FMT_RST;
            drv_ff    <= pasp_pkg::DRV_RST;
            ofs_ff    <= pasp_pkg::OFS_RST;
            rdata_ff  <= 8'h00;
            shadow_ff <= {pasp_pkg::FMT_RST, pasp_pkg::DRV_RST, pasp_pkg::OFS_RST};
            req_ff    <= 1'b0;
            dirty_ff  <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            err_s1_ff <= 1'b0;
            err_s2_ff <= 1'b0;
            cm_s1_ff  <= 1'b0;
            cm_s2_ff  <= 1'b0;
            ibck_ff   <= 1'b0;
        end
        else
        begin
            fmt_ff    <= nxt_fmt;
            drv_ff    <= nxt_drv;
            ofs_ff    <= nxt_ofs;
            rdata_ff  <= nxt_rdata;
            shadow_ff <= nxt_shadow;
            req_ff    <= nxt_req;
            dirty_ff  <= nxt_dirty;
            ack_s1_ff <= ack_ff;
            ack_s2_ff <= ack_s1_ff;
            err_s1_ff <= (st_ff != pasp_pkg::LNK_RUN);
            err_s2_ff <= err_s1_ff;
            cm_s1_ff  <= controller_mode_i;
            cm_s2_ff  <= cm_s1_ff;
            ibck_ff   <= cm_s2_ff && drv_ff[pasp_pkg::INT_BCK_BIT];
        end
    end

    assign reg_rdata_o    = rdata_ff;
    assign bus_error_o    = err_s2_ff;
    assign int_bclk_sel_o = ibck_ff;

    // ---------------- link clock domain
    logic                    lrs1_ff, lrst_n_ff;
    logic                    req_s1_ff, req_s2_ff, req_s3_ff, pend_ff;
    logic                    lcm_s1_ff, lcm_s2_ff, fs_s1_ff, fs_s2_ff, lvl_ff;
    logic [7:0]              lfmt_ff, ldrv_ff;
    logic [4:0]              lofs_ff;
    logic [10:0]             cnt_ff, flen_ff, plen_ff, icnt_ff;
    logic                    ifs_ff, fso_ff, fsoe_ff;
    pasp_pkg::pasp_link_state_type nxt_st;
    logic [1:0]              proto;
    logic                    tdm, lvl, fs_src, half_start, frame_start, mism, apply;
    logic [10:0]             pos, nxt_icnt;
    logic                    nxt_ifs;
    logic [1:0]              pin_bit, pin_act, pin_lsb;

    always_ff @(posedge bit_clock_i or negedge rsys_n_ff)
    begin
        if (!rsys_n_ff)
        begin
            lrs1_ff   <= 1'b0;
            lrst_n_ff <= 1'b0;
        end
        else
        begin
            lrs1_ff   <= 1'b1;
            lrst_n_ff <= lrs1_ff;
        end
    end

    always_comb
    begin
        proto  = lfmt_ff[pasp_pkg::PROTO_MSB:pasp_pkg::PROTO_LSB];
        tdm    = !(proto == pasp_pkg::PROTO_I2S || proto == pasp_pkg::PROTO_LJ);
        fs_src = (lcm_s2_ff && ldrv_ff[pasp_pkg::INT_FS_BIT]) ? ifs_ff : fs_s2_ff;
        // lvl high marks the frame pulse in TDM and the left half otherwise
        lvl = fs_src ^ lfmt_ff[pasp_pkg::FS_INV_BIT] ^ (proto == pasp_pkg::PROTO_I2S);
        frame_start = lvl && !lvl_ff;
        half_start  = tdm ? frame_start : (lvl != lvl_ff);
        pos   = half_start ? 11'h000 : cnt_ff;
        mism  = frame_start && (plen_ff != 11'h000) && (flen_ff != plen_ff);
        apply = pend_ff && frame_start;
        nxt_st = st_ff;
        case (st_ff)
            pasp_pkg::LNK_RUN:
                if (mism && !lfmt_ff[pasp_pkg::ERR_OFF_BIT])
                    nxt_st = lfmt_ff[pasp_pkg::RES_OFF_BIT] ? pasp_pkg::LNK_DOWN
                                                             : pasp_pkg::LNK_ERR;
            pasp_pkg::LNK_ERR:
                if ((frame_start && !mism) || lfmt_ff[pasp_pkg::ERR_OFF_BIT])
                    nxt_st = pasp_pkg::LNK_RUN;
            pasp_pkg::LNK_DOWN:
                if (apply)
                    nxt_st = pasp_pkg::LNK_RUN;
            default:
                nxt_st = pasp_pkg::LNK_RUN;
        endcase
        // internal frame sync in the protocol's normal sense
        nxt_icnt = (icnt_ff == pasp_pkg::FRAME_BCLKS - 11'h001) ? 11'h000 : icnt_ff + 11'h001;
        if (tdm)
            nxt_ifs = nxt_icnt < (ldrv_ff[pasp_pkg::WIDE_BIT] ? 11'h002 : 11'h001);
        else
            nxt_ifs = (nxt_icnt < pasp_pkg::HALF_BCLKS) ^ (proto == pasp_pkg::PROTO_I2S);
    end

    always_ff @(posedge bit_clock_i or negedge lrst_n_ff)
    begin
        if (!lrst_n_ff)
        begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            ack_ff    <= 1'b0;
            pend_ff   <= 1'b0;
            lcm_s1_ff <= 1'b0;
            lcm_s2_ff <= 1'b0;
            fs_s1_ff  <= 1'b0;
            fs_s2_ff  <= 1'b0;
            lvl_ff    <= 1'b0;
            lfmt_ff   <= pasp_pkg::FMT_RST;
            ldrv_ff   <= pasp_pkg::DRV_RST;
            lofs_ff   <= pasp_pkg::OFS_RST;
            cnt_ff    <= 11'h000;
            flen_ff   <= 11'h000;
            plen_ff   <= 11'h000;
            icnt_ff   <= 11'h000;
            ifs_ff    <= 1'b0;
            fso_ff    <= 1'b0;
            fsoe_ff   <= 1'b0;
            st_ff     <= pasp_pkg::LNK_RUN;
        end
        else
        begin
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            ack_ff    <= apply ? req_s3_ff : ack_ff;
            pend_ff   <= (req_s2_ff != req_s3_ff) || (pend_ff && !apply);
            lcm_s1_ff <= controller_mode_i;
            lcm_s2_ff <= lcm_s1_ff;
            fs_s1_ff  <= frame_sync_i;
            fs_s2_ff  <= fs_s1_ff;
            lvl_ff    <= lvl;
            {lfmt_ff, ldrv_ff, lofs_ff} <= apply ? shadow_ff : {lfmt_ff, ldrv_ff, lofs_ff};
            cnt_ff    <= pos + 11'h001;
            // held at 0 until the first frame start so the cut first frame is never compared
            flen_ff   <= frame_start ? 11'h001
                       : (flen_ff == 11'h000) ? 11'h000 : flen_ff + 11'h001;
            plen_ff   <= frame_start ? flen_ff : plen_ff;
            icnt_ff   <= nxt_icnt;
            ifs_ff    <= nxt_ifs;
            fso_ff    <= nxt_ifs ^ lfmt_ff[pasp_pkg::FS_INV_BIT];
            fsoe_ff   <= lcm_s2_ff;
            st_ff     <= nxt_st;
        end
    end

    assign frame_sync_o    = fso_ff;
    assign frame_sync_oe_o = fsoe_ff;

    // per-pin slot placement
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        logic [31:0] word;
        logic [4:0]  code;
        logic [5:0]  wl;
        logic [10:0] first, rel;
        logic        side_ok, nxt_act;
        logic        d_ff, a_ff, l_ff;

        always_comb
        begin
            word  = (p == 0) ? tx_word0_i : tx_word1_i;
            code  = (p == 0) ? tx_slot0_i : tx_slot1_i;
            wl    = word_len(lfmt_ff[pasp_pkg::WLEN_MSB:pasp_pkg::WLEN_LSB]);
            // I2S puts the msb one bit clock after the half edge
            first = 11'(proto == pasp_pkg::PROTO_I2S) + 11'(lofs_ff)
                  + 11'(slot_index(code, tdm)) * 11'(wl);
            rel   = pos - first;
            side_ok = tdm || (code[4] == !lvl);
            nxt_act = tx_en_i[p] && side_ok && (st_ff == pasp_pkg::LNK_RUN)
                    && (pos >= first) && (rel < 11'(wl));
        end

        always_ff @(posedge bit_clock_i or negedge lrst_n_ff)
        begin
            if (!lrst_n_ff)
            begin
                d_ff <= 1'b0;
                a_ff <= 1'b0;
                l_ff <= 1'b0;
            end
            else
            begin
                d_ff <= word[5'(5'h1F - rel[4:0])];
                a_ff <= nxt_act;
                l_ff <= (rel == 11'(wl - 6'h01));
            end
        end

        assign pin_bit[p] = d_ff;
        assign pin_act[p] = a_ff;
        assign pin_lsb[p] = l_ff;
    end

    pasp_pin_stage u_pins (
        .bclk_i      (bit_clock_i),
        .rst_n_i     (lrst_n_ff),
        .bit_i       (pin_bit),
        .act_i       (pin_act),
        .lsb_i       (pin_lsb),
        .fill_hiz_i  (ldrv_ff[pasp_pkg::FILL_BIT]),
        .lsb_half_i  (ldrv_ff[pasp_pkg::LSBH_BIT]),
        .keep_mode_i (ldrv_ff[pasp_pkg::KEEP_MSB:pasp_pkg::KEEP_LSB]),
        .edge_late_i (lfmt_ff[pasp_pkg::BCK_INV_BIT] ^ ldrv_ff[pasp_pkg::EDGE_BIT]),
        .data_o      (data_o),
        .data_oe_o   (data_oe_o),
        .keeper_o    (keeper_o)
    );

    fmt_write_a: assert property (@(posedge clock_i) disable iff (!rsys_n_ff)
        (reg_wr_i && reg_addr_i == pasp_pkg::FMT_ADDR) |=> (fmt_ff == $past(reg_wdata_i)))
        else $error("format register not written");
    ofs_upper_a: assert property (@(posedge clock_i) disable iff (!rsys_n_ff)
        (reg_addr_i == pasp_pkg::OFS_ADDR) |=> (reg_rdata_o[7:5] == 3'h0))
        else $error("offset upper bits not zero");
    reset_value_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(rsys_n_ff) |-> (fmt_ff == pasp_pkg::FMT_RST && ofs_ff == pasp_pkg::OFS_RST))
        else $error("register reset value wrong");
    tdm_narrow_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (tdm && !ldrv_ff[pasp_pkg::WIDE_BIT] && $rose(ifs_ff) && !apply) |=> !ifs_ff)
        else $error("narrow frame sync not one bit clock");
    tdm_wide_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (tdm && ldrv_ff[pasp_pkg::WIDE_BIT] && $rose(ifs_ff) && !pend_ff) |=> ifs_ff ##1 !ifs_ff)
        else $error("wide frame sync not two bit clocks");
    err_catch_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (st_ff == pasp_pkg::LNK_RUN && mism && !lfmt_ff[pasp_pkg::ERR_OFF_BIT])
        |=> (st_ff != pasp_pkg::LNK_RUN) ##1 (pin_act == 2'h0))
        else $error("bus error not caught");
    err_ignore_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (st_ff == pasp_pkg::LNK_RUN && lfmt_ff[pasp_pkg::ERR_OFF_BIT]) |=> (st_ff == pasp_pkg::LNK_RUN))
        else $error("error taken while detection off");
    down_hold_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (st_ff == pasp_pkg::LNK_DOWN && !apply) |=> (st_ff == pasp_pkg::LNK_DOWN))
        else $error("left power down without host");
    slot_zero_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        (frame_start && tdm && lofs_ff == 5'h00 && tx_slot0_i == 5'h00 && tx_en_i[0]
         && st_ff == pasp_pkg::LNK_RUN) |=> pin_act[0])
        else $error("slot 0 msb not at frame start");
    cfg_frame_a: assert property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        !frame_start |=> $stable(lofs_ff))
        else $error("settings changed mid frame");

    apply_c: cover property (@(posedge bit_clock_i) disable iff (!lrst_n_ff) apply);
    down_c: cover property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        st_ff == pasp_pkg::LNK_DOWN);
    resume_c: cover property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        st_ff == pasp_pkg::LNK_ERR ##1 st_ff == pasp_pkg::LNK_RUN);
    i2s_right_c: cover property (@(posedge bit_clock_i) disable iff (!lrst_n_ff)
        proto == pasp_pkg::PROTO_I2S && !lvl && pin_act[1]);
endmodule : pasp_tx_format
`default_nettype wire

// >>> bench/pasp_host_model.sv
// far-side controller model: frame sync of a fixed frame length, 8 bit clocks shorter for frames started with short_i high
`timescale 1ns/1ps
`default_nettype none
module pasp_host_model #(
    parameter int FRAME_LEN = 64
) (
    input  wire logic bclk_i,
    input  wire logic rst_n_i,
    input  wire logic short_i,
    output logic      fsync_o
);
    int cnt;
    int len;
    // moves on the falling edge, away from the sampling edge
    always @(negedge bclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= 0;
            len <= FRAME_LEN;
            fsync_o <= 1'b0;
        end
        else
        begin
            fsync_o <= (cnt == 0);
            cnt <= (cnt + 1 >= len) ? 0 : cnt + 1;
            if (cnt == 0)
                len <= short_i ? FRAME_LEN - 8 : FRAME_LEN;
        end
    end
endmodule : pasp_host_model
`default_nettype wire

// >>> bench/pasp_tx_format_tb_top.sv
// self-checking bench for the primary serial port transmit formatter
`timescale 1ns/1ps
`default_nettype none
module pasp_tx_format_tb_top;
    logic        clock_i = 1'b0;
    logic        bclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        ctrl = 1'b0;
    logic        short = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        err, ibs, fso, fsoe, fsync;
    logic [1:0]  dout, doe, keep;
    logic [31:0] cap = 32'h0;
    int          cnt = 0;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    localparam logic [31:0] W0 = 32'hC35A_96E1;

    always #4 clock_i = ~clock_i;
    always #3 bclk = ~bclk;

    pasp_tx_format pasp_tx_format_i (.clock_i(clock_i), .rst_n_i(rst_n), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .bus_error_o(err),
        .int_bclk_sel_o(ibs), .bit_clock_i(bclk), .frame_sync_i(fsync),
        .controller_mode_i(ctrl), .tx_word0_i(W0), .tx_word1_i(32'h1234_5678),
        .tx_slot0_i(5'h00), .tx_slot1_i(5'h01), .tx_en_i(2'h3), .frame_sync_o(fso),
        .frame_sync_oe_o(fsoe), .data_o(dout), .data_oe_o(doe), .keeper_o(keep));
    pasp_host_model pasp_host_model_i (.bclk_i(bclk), .rst_n_i(rst_n), .short_i(short),
        .fsync_o(fsync));

    always @(posedge bclk)
    begin
        if (doe[0])
        begin
            cap <= {cap[30:0], dout[0]};
            cnt <= cnt + 1;
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wrr

    task automatic rdr(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr <= a;
        @(posedge clock_i);
        #1 chk({24'h0, rdata}, {24'h0, e});
    endtask : rdr

    task automatic wb(input int n);
        repeat (n) @(posedge bclk);
    endtask : wb

    task automatic ef(input logic v);
        int k;
        k = 0;
        while (err !== v && k < 2000)
        begin
            @(posedge clock_i);
            k++;
        end
        chk({31'h0, err}, {31'h0, v});
    endtask : ef

    // exactly one frame 8 bit clocks short: the model latches the length at its frame start
    task automatic sp();
        @(posedge bclk iff fsync);
        short <= 1'b1;
        @(posedge bclk iff fsync);
        short <= 1'b0;
    endtask : sp

    initial
    begin
        int k;
        int wl;
        logic [63:0] m;
        repeat (20) @(posedge clock_i);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        rdr(pasp_pkg::FMT_ADDR, pasp_pkg::FMT_RST);
        rdr(pasp_pkg::DRV_ADDR, 8'h00);
        rdr(pasp_pkg::OFS_ADDR, 8'h00);
        wrr(pasp_pkg::OFS_ADDR, 8'h1F);
        rdr(pasp_pkg::OFS_ADDR, 8'h1F);
        wrr(pasp_pkg::OFS_ADDR, 8'h00);
        wrr(8'h1D, 8'hA5);
        rdr(8'h1D, 8'h00);
        wrr(pasp_pkg::DRV_ADDR, 8'h40);
        rdr(pasp_pkg::DRV_ADDR, 8'h40);
        for (int c = 0; c < 4; c++)
        begin
            wl = (c == 3) ? 32 : 16 + 4 * c;
            wrr(pasp_pkg::FMT_ADDR, {2'h0, c[1:0], 4'h0});
            wrr(pasp_pkg::DRV_ADDR, {c[0], 7'h40});
            wb(200);
            // start the window on the first edge after a burst
            @(posedge bclk iff doe[0]);
            @(posedge bclk iff !doe[0]);
            k = cnt;
            wb(128);
            @(posedge bclk iff !doe[0]);
            m = (64'h1 << wl) - 64'h1;
            chk(cnt - k, 2 * wl);
            chk(cap & m[31:0], W0 >> (32 - wl));
        end
        wrr(pasp_pkg::FMT_ADDR, 8'h00);
        wb(200);
        sp();
        ef(1'b1);
        ef(1'b0);
        wrr(pasp_pkg::FMT_ADDR, 8'h01);
        wb(200);
        sp();
        ef(1'b1);
        wb(400);
        chk({31'h0, err}, 32'h1);
        wrr(pasp_pkg::FMT_ADDR, 8'h00);
        ef(1'b0);
        wrr(pasp_pkg::FMT_ADDR, 8'h02);
        wb(200);
        sp();
        wb(400);
        chk({31'h0, err}, 32'h0);
        ctrl <= 1'b1;
        for (int w = 1; w <= 2; w++)
        begin
            // keeper always on, internal sync and clock, narrow then wide pulse
            wrr(pasp_pkg::DRV_ADDR, 8'h4D + 8'(w));
            wb(200);
            k = 0;
            repeat (int'(pasp_pkg::FRAME_BCLKS))
            begin
                @(negedge bclk);
                k += int'(fso);
            end
            chk(k, w);
            chk({30'h0, ibs, fsoe}, 32'h3);
            chk({30'h0, keep}, 32'h3);
        end
        results();
    end
endmodule : pasp_tx_format_tb_top
`default_nettype wire
